// >>> logic/ucmc_consts.svh
`ifndef UCMC_CONSTS_SVH
`define UCMC_CONSTS_SVH

// ****************************************
// clock and timing
// ****************************************
`define UCMC_CLK_HZ         200000000
`define UCMC_CLK_PERIOD_NS  5
`define UCMC_MIN_PULSE_NS   5
// least time: round up, never below one cycle
`define UCMC_MIN_PULSE_CYC  ((`UCMC_MIN_PULSE_NS + `UCMC_CLK_PERIOD_NS - 1) / `UCMC_CLK_PERIOD_NS)
`define UCMC_SPAN_MAX_S     15000
`define UCMC_SPAN_AVG_S     1500
// longest time: round down
`define UCMC_SPAN_CYC       (64'd`UCMC_SPAN_MAX_S * 64'd`UCMC_CLK_HZ)
`define UCMC_SPAN_AVG_CYC   (64'd`UCMC_SPAN_AVG_S * 64'd`UCMC_CLK_HZ)
`define UCMC_AVG_COUNT      100

// ****************************************
// widths and limits
// ****************************************
`define UCMC_PRI_W          48
`define UCMC_SEC_W          32
`define UCMC_AVGN_W         7
`define UCMC_ACCUM_MAX      48'h00_E8D4_A50F_FF

// ****************************************
// threshold placement, percent of amplitude
// ****************************************
`define UCMC_THR_LOW_PCT    7'h0A
`define UCMC_THR_HIGH_PCT   7'h5A
`define UCMC_THR_MID_PCT    7'h32

`endif

// >>> logic/ucmc_core.sv
`timescale 1ns/100ps
`include "ucmc_consts.svh"

// Operation
// - quotient pairs: one/two, two/one, three/one
// - aperture counts denominator cycles for quotient
// - edge durations: input one, common, auto levels
// - common routing forced during edge durations
// - explicit levels override automatic threshold placement in edge durations
// - span limited; averaging lowers the limit
// - edge duration gate follows transition, not aperture
// - input two conditioning copied from one in edge durations
// - single or averaged interval; minimum pulse width
// - interval starts input one, stops input two
// - common routing takes both events from one
// - per-input edge polarity select
// - delay from start keeps stop disarmed
// - stops in delay dropped; first later stop ends
// - accumulator counts up to ten^12 minus one
// - running total kept across fetches
// - arm stop halts accumulate; aperture ignored
// - external arming starts and stops accumulate
// - gated accumulate counts during one other cycle
// - trigger pulse trains feed the counter registers
module ucmc_core #(
	parameter int     MIN_PULSE_CYC = `UCMC_MIN_PULSE_CYC,
	parameter longint SPAN_CYC      = `UCMC_SPAN_CYC,
	parameter longint SPAN_AVG_CYC  = `UCMC_SPAN_AVG_CYC,
	parameter int     AVG_COUNT     = `UCMC_AVG_COUNT
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic [2:0]       trigIn,
	input  ucmc_pkg::ucmc_cfg_s   cfg,
	input  ucmc_pkg::ucmc_cond_s  in1Cond,
	input  ucmc_pkg::ucmc_cond_s  in2Cond,
	input  wire logic             initStart,
	input  wire logic             armStop,
	input  wire logic             extArmStart,
	input  wire logic             extArmStop,
	input  wire logic             fetch,
	output ucmc_pkg::ucmc_front_s front,
	output ucmc_pkg::ucmc_result_s result,
	output logic [2:0]            trigPulse,
	output logic                  busy,
	output logic                  stopArmed
);
	import ucmc_pkg::*;

	if (AVG_COUNT < 1 || AVG_COUNT > 127) begin : g_bad_avg
		$error("ucmc_core: AVG_COUNT out of range");
	end
	if (SPAN_AVG_CYC < 1 || SPAN_CYC < SPAN_AVG_CYC || SPAN_CYC >= 64'h1_0000_0000_0000) begin : g_bad_span
		$error("ucmc_core: span limits out of range");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARM,
		ST_DELAY,
		ST_RUN
	} ucmc_state_e;

	// ****************************************
	// state
	// ****************************************
	ucmc_state_e  st_ff;
	ucmc_state_e  nxt_st;
	logic [47:0]  meas_ff;
	logic [47:0]  nxt_meas;
	logic [31:0]  aux_ff;
	logic [31:0]  nxt_aux;
	logic [47:0]  num_ff;
	logic [47:0]  nxt_num;
	logic [31:0]  den_ff;
	logic [31:0]  nxt_den;
	logic [47:0]  sum_ff;
	logic [47:0]  nxt_sum;
	logic [6:0]   avgN_ff;
	logic [6:0]   nxt_avgN;
	ucmc_result_s res_ff;
	ucmc_result_s nxt_res;
	ucmc_front_s  front_ff;
	ucmc_front_s  nxt_front;

	logic       edgeDur;
	logic       isInterval;
	logic [2:0] slopeEff;
	logic [2:0] detLevel;
	logic [2:0] evt;
	logic       numEvt;
	logic       denEvt;
	logic       accEvt;
	logic       cntEvt;
	logic       gateEvt;
	logic [47:0] spanLim;

	// ****************************************
	// edge detectors, one per input
	// ****************************************
	assign edgeDur    = (cfg.fn == FN_LEADING_EDGE_DURATION) ||
	                    (cfg.fn == FN_TRAILING_EDGE_DURATION);
	assign isInterval = edgeDur || (cfg.fn == FN_START_STOP_INTERVAL);

	// edge durations fix the polarity; otherwise each input has its own
	always_comb begin
		slopeEff = cfg.slopeNeg;
		if (edgeDur) begin
			slopeEff[1:0] = (cfg.fn == FN_TRAILING_EDGE_DURATION) ? 2'h3 : 2'h0;
		end
	end

	// under common routing outside edge durations the stop detector watches input one as well
	always_comb begin
		detLevel    = trigIn;
		if (front_ff.routeCommon && !edgeDur) begin
			detLevel[1] = trigIn[0];
		end
	end

	for (genvar i = 0; i < 3; i++) begin : g_det
		ucmc_edge_sel #(
			.MIN_WIDTH (MIN_PULSE_CYC)
		) u_det (
			.sys_clk   (sys_clk),
			.reset_n   (reset_n),
			.trigLevel (detLevel[i]),
			.slopeNeg  (slopeEff[i]),
			.evt       (evt[i])
		);
	end

	assign trigPulse = evt;

	// ****************************************
	// event routing per function
	// ****************************************
	always_comb begin
		case (cfg.pair)
			PAIR_TWO_OVER_ONE: begin
				numEvt = evt[1];
				denEvt = evt[0];
			end
			PAIR_THREE_OVER_ONE: begin
				numEvt = evt[2];
				denEvt = evt[0];
			end
			default: begin
				numEvt = evt[0];
				denEvt = evt[1];
			end
		endcase
		accEvt  = cfg.accumSrc ? evt[1] : evt[0];
		cntEvt  = cfg.gateSwap ? evt[1] : evt[0];
		gateEvt = cfg.gateSwap ? evt[0] : evt[1];
		spanLim = cfg.avgOn ? 48'(SPAN_AVG_CYC) : 48'(SPAN_CYC);
	end

	// ****************************************
	// front-end control
	// ****************************************
	// in edge durations routing is forced, not requested, so a later clear of the request is ignored
	always_comb begin
		nxt_front.routeCommon = edgeDur || cfg.routeCommon;
		nxt_front.autoLevel   = edgeDur ? !cfg.manualLevel : cfg.autoLevel;
		nxt_front.in2Cond     = edgeDur ? in1Cond : in2Cond;
		nxt_front.in1ThrPct   = `UCMC_THR_MID_PCT;
		nxt_front.in2ThrPct   = `UCMC_THR_MID_PCT;
		if (cfg.fn == FN_LEADING_EDGE_DURATION) begin
			nxt_front.in1ThrPct = `UCMC_THR_LOW_PCT;
			nxt_front.in2ThrPct = `UCMC_THR_HIGH_PCT;
		end else if (cfg.fn == FN_TRAILING_EDGE_DURATION) begin
			nxt_front.in1ThrPct = `UCMC_THR_HIGH_PCT;
			nxt_front.in2ThrPct = `UCMC_THR_LOW_PCT;
		end
	end

	// ****************************************
	// measurement sequencer
	// ****************************************
	always_comb begin
		logic [47:0] sumNow;
		sumNow   = sum_ff + meas_ff;
		nxt_st   = st_ff;
		nxt_meas = meas_ff;
		nxt_aux  = aux_ff;
		nxt_num  = num_ff;
		nxt_den  = den_ff;
		nxt_sum  = sum_ff;
		nxt_avgN = avgN_ff;
		nxt_res  = res_ff;
		// clear first so a completion in the same cycle wins
		if (fetch) begin
			nxt_res.valid = 1'b0;
		end
		case (st_ff)
			ST_IDLE: begin
				if (initStart) begin
					nxt_st   = ST_ARM;
					nxt_res  = '0;
					nxt_num  = '0;
					nxt_den  = '0;
					nxt_sum  = '0;
					nxt_avgN = '0;
					nxt_meas = '0;
				end
			end
			ST_ARM: begin
				nxt_meas = '0;
				nxt_aux  = '0;
				if (armStop) begin
					nxt_st = ST_IDLE;
				end else begin
					case (cfg.fn)
						FN_FREQ_QUOTIENT: begin
							if (denEvt) begin
								nxt_st = ST_RUN;
							end
						end
						FN_EVENT_ACCUMULATE: begin
							if (!cfg.extArmSel || extArmStart) begin
								nxt_st = ST_RUN;
							end
						end
						FN_GATED_ACCUMULATE: begin
							if (gateEvt) begin
								nxt_st = ST_RUN;
							end
						end
						default: begin
							// the start edge opens the gate, aperture unused
							if (evt[0]) begin
								nxt_meas = 48'h1;
								nxt_st   = (cfg.delayOn && !edgeDur &&
								            cfg.delayCycles > 32'h1) ? ST_DELAY : ST_RUN;
							end
						end
					endcase
				end
			end
			ST_DELAY: begin
				// stop edges in here are simply not looked at
				nxt_meas = meas_ff + 48'h1;
				nxt_aux  = aux_ff + 32'h1;
				if (armStop) begin
					nxt_st = ST_IDLE;
				end else if (aux_ff + 32'h2 >= cfg.delayCycles) begin
					nxt_st = ST_RUN;
				end
			end
			ST_RUN: begin
				case (cfg.fn)
					FN_FREQ_QUOTIENT: begin
						if (numEvt) begin
							nxt_num = num_ff + 48'h1;
						end
						if (armStop) begin
							nxt_st = ST_IDLE;
						end else if (denEvt) begin
							nxt_den = den_ff + 32'h1;
							if (den_ff + 32'h1 >= cfg.apertureCycles) begin
								nxt_st            = ST_IDLE;
								nxt_res.valid     = 1'b1;
								nxt_res.primary   = numEvt ? num_ff + 48'h1 : num_ff;
								nxt_res.secondary = den_ff + 32'h1;
							end
						end
					end
					FN_EVENT_ACCUMULATE: begin
						// live total; a fetch never clears it
						if (accEvt) begin
							if (num_ff == `UCMC_ACCUM_MAX) begin
								nxt_res.overflow = 1'b1;
							end else begin
								nxt_num         = num_ff + 48'h1;
								nxt_res.primary = num_ff + 48'h1;
							end
						end
						if (armStop || (cfg.extArmSel && extArmStop)) begin
							nxt_st        = ST_IDLE;
							nxt_res.valid = 1'b1;
						end
					end
					FN_GATED_ACCUMULATE: begin
						if (armStop) begin
							nxt_st = ST_IDLE;
						end else if (gateEvt) begin
							nxt_st          = ST_IDLE;
							nxt_res.valid   = 1'b1;
							nxt_res.primary = cntEvt ? num_ff + 48'h1 : num_ff;
						end else if (cntEvt) begin
							nxt_num = num_ff + 48'h1;
						end
					end
					default: begin
						nxt_meas = meas_ff + 48'h1;
						if (armStop) begin
							nxt_st = ST_IDLE;
						end else if (evt[1]) begin
							if (cfg.avgOn && avgN_ff < 7'(AVG_COUNT - 1)) begin
								nxt_sum  = sumNow;
								nxt_avgN = avgN_ff + 7'h1;
								nxt_st   = ST_ARM;
							end else begin
								nxt_st            = ST_IDLE;
								nxt_res.valid     = 1'b1;
								nxt_res.primary   = sumNow;
								nxt_res.secondary = 32'(avgN_ff) + 32'h1;
							end
						end else if (meas_ff >= spanLim) begin
							nxt_st            = ST_IDLE;
							nxt_res.valid     = 1'b1;
							nxt_res.overflow  = 1'b1;
							nxt_res.primary   = sumNow;
							nxt_res.secondary = 32'(avgN_ff) + 32'h1;
						end
					end
				endcase
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff    <= ST_IDLE;
			meas_ff  <= '0;
			aux_ff   <= '0;
			num_ff   <= '0;
			den_ff   <= '0;
			sum_ff   <= '0;
			avgN_ff  <= '0;
			res_ff   <= '0;
			front_ff <= '0;
		end else begin
			st_ff    <= nxt_st;
			meas_ff  <= nxt_meas;
			aux_ff   <= nxt_aux;
			num_ff   <= nxt_num;
			den_ff   <= nxt_den;
			sum_ff   <= nxt_sum;
			avgN_ff  <= nxt_avgN;
			res_ff   <= nxt_res;
			front_ff <= nxt_front;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign front     = front_ff;
	assign result    = res_ff;
	assign busy      = (st_ff != ST_IDLE);
	// stop is only looked at here; an early stop edge is lost, not queued
	assign stopArmed = (st_ff == ST_RUN) && isInterval;

endmodule // ucmc_core

// >>> logic/ucmc_edge_sel.sv
`timescale 1ns/100ps
`include "ucmc_consts.svh"

module ucmc_edge_sel #(
	parameter int MIN_WIDTH = `UCMC_MIN_PULSE_CYC
) (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic trigLevel,
	input  wire logic slopeNeg,
	output logic      evt
);
	import ucmc_pkg::*;

	if (MIN_WIDTH < 1 || MIN_WIDTH > 255) begin : g_bad_width
		$error("ucmc_edge_sel: MIN_WIDTH out of range");
	end

	logic       active;
	logic [7:0] width_ff;
	logic [7:0] nxt_width;

	// ****************************************
	// polarity select and width qualification
	// ****************************************
	// active phase of the selected edge; a pulse narrower than MIN_WIDTH never fires
	always_comb begin
		active = trigLevel ^ slopeNeg;
		if (!active) begin
			nxt_width = 8'h00;
		end else if (width_ff == 8'(MIN_WIDTH)) begin
			nxt_width = width_ff;   // saturate, one event per edge
		end else begin
			nxt_width = width_ff + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			width_ff <= 8'h00;
		end else begin
			width_ff <= nxt_width;
		end
	end

	assign evt = active && (width_ff == 8'(MIN_WIDTH - 1));

endmodule // ucmc_edge_sel

// >>> logic/ucmc_pkg.sv
package ucmc_pkg;

	// ****************************************
	// measurement functions and channel pairings
	// ****************************************
	typedef enum logic [2:0] {
		FN_FREQ_QUOTIENT,
		FN_LEADING_EDGE_DURATION,
		FN_TRAILING_EDGE_DURATION,
		FN_START_STOP_INTERVAL,
		FN_EVENT_ACCUMULATE,
		FN_GATED_ACCUMULATE
	} ucmc_fn_e;

	typedef enum logic [1:0] {
		PAIR_ONE_OVER_TWO,
		PAIR_TWO_OVER_ONE,
		PAIR_THREE_OVER_ONE
	} ucmc_pair_e;

	// input conditioning of one front end
	typedef struct packed {
		logic acCouple;
		logic imp50;
		logic hystMin;
	} ucmc_cond_s;

	// measurement configuration from the control processor
	typedef struct packed {
		ucmc_fn_e    fn;
		ucmc_pair_e  pair;
		logic [31:0] apertureCycles;
		logic [2:0]  slopeNeg;
		logic        routeCommon;
		logic        autoLevel;
		logic        manualLevel;
		logic        avgOn;
		logic        delayOn;
		logic [31:0] delayCycles;
		logic        accumSrc;
		logic        extArmSel;
		logic        gateSwap;
	} ucmc_cfg_s;

	// effective front-end settings driven back to the comparators
	typedef struct packed {
		logic       routeCommon;
		logic       autoLevel;
		logic [6:0] in1ThrPct;
		logic [6:0] in2ThrPct;
		ucmc_cond_s in2Cond;
	} ucmc_front_s;

	typedef struct packed {
		logic        valid;
		logic        overflow;
		logic [47:0] primary;
		logic [31:0] secondary;
	} ucmc_result_s;

endpackage

// >>> tb/tb.sv
`timescale 1ns/100ps
`include "ucmc_consts.svh"
// ****************
// testbench top
// ****************
module tb;
	import ucmc_pkg::*;
	logic         sys_clk, reset_n, busy, stopArmed;
	logic         initStart, armStop, extArmStart, extArmStop, fetch;
	logic [2:0]   inv, trigIn, trigPulse;
	ucmc_cfg_s    cfg;
	ucmc_cond_s   in1Cond, in2Cond;
	ucmc_front_s  front;
	ucmc_result_s result;
	int           n_errors, cmp_count;
	// short spans keep the overflow case cheap
	ucmc_core #(.SPAN_CYC(2000), .SPAN_AVG_CYC(200), .AVG_COUNT(4)) i_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .trigIn(trigIn), .cfg(cfg),
		.in1Cond(in1Cond), .in2Cond(in2Cond), .initStart(initStart),
		.armStop(armStop), .extArmStart(extArmStart), .extArmStop(extArmStop),
		.fetch(fetch), .front(front), .result(result), .trigPulse(trigPulse),
		.busy(busy), .stopArmed(stopArmed));
	ucmc_source i_src (.sys_clk(sys_clk), .inv(inv), .trigIn(trigIn));
	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ****************
	// tasks
	// ****************
	task automatic check(input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t ns: saw %0h want %0h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// one-cycle strobe: 0 start, 1 arm stop, 2 ext start, 3 ext stop, 4 fetch
	task automatic ctl(input int w);
		@(negedge sys_clk);
		{fetch, extArmStop, extArmStart, armStop, initStart} = 5'(1 << w);
		@(negedge sys_clk);
		{fetch, extArmStop, extArmStart, armStop, initStart} = 5'h00;
	endtask
	// bounded wait, a hang shows as a busy mismatch
	task automatic got(input logic [47:0] p);
		for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge sys_clk);
		check(64'(busy), 64'h0);
		check(64'(result.valid), 64'h1);
		check(64'(result.primary), 64'(p));
	endtask
	task automatic res(input logic [47:0] p, input logic [31:0] s);
		got(p);
		check(64'(result.secondary), 64'(s));
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog, well beyond the few thousand cycles of the run
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
	// ****************
	// tests
	// ****************
	initial begin
		{reset_n, initStart, armStop, extArmStart, extArmStop, fetch} = 6'h00;
		cfg = '0;
		cfg.apertureCycles = 32'h3;
		in1Cond = 3'h5;
		in2Cond = 3'h2;
		inv = 3'h0;
		n_errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk) reset_n = 1'b1;
		// three gate cycles of two numerator events, every pairing
		for (int p = 0; p < 3; p++) begin
			cfg.pair = ucmc_pair_e'(p);
			ctl(0);
			tick(1);
			repeat (3) begin
				i_src.pulse(p == 0 ? 1 : 0, 1);
				i_src.pulse(p, 2);
			end
			i_src.pulse(p == 0 ? 1 : 0, 1);
			res(48'h6, 32'h3);
		end
		$display("test quotient done");
		// early stop dropped, both slopes
		cfg = '0;
		cfg.fn = FN_START_STOP_INTERVAL;
		for (int s = 0; s < 2; s++) begin
			cfg.slopeNeg = {1'b0, s[0], s[0]};
			inv = cfg.slopeNeg;
			tick(2);
			ctl(0);
			i_src.pulse(1, 1);
			i_src.pulse(0, 1);
			tick(2);
			i_src.pulse(1, 1);
			res(48'h4, 32'h1);
		end
		ctl(4);
		check(64'(result.valid), 64'h0);
		check(64'(result.primary), 64'h4);
		check(64'(front.in2Cond), 64'(in2Cond));
		cfg.slopeNeg = 3'h0;
		inv = 3'h0;
		// stop inside the delay is ignored, the next one ends it
		cfg.delayOn = 1'b1;
		cfg.delayCycles = 32'h6;
		ctl(0);
		i_src.pulse(0, 1);
		i_src.pulse(1, 1);
		check(64'(stopArmed), 64'h0);
		tick(6);
		check(64'(stopArmed), 64'h1);
		i_src.pulse(1, 1);
		res(48'hA, 32'h1);
		cfg.delayOn = 1'b0;
		cfg.routeCommon = 1'b1;
		ctl(0);
		i_src.pulse(0, 1);
		tick(3);
		i_src.pulse(0, 1);
		res(48'h5, 32'h1);
		cfg.routeCommon = 1'b0;
		cfg.avgOn = 1'b1;
		ctl(0);
		repeat (4) begin
			i_src.pulse(0, 1);
			i_src.pulse(1, 1);
		end
		res(48'h8, 32'h4);
		// abort, then a start with no stop runs into the span limit
		cfg.avgOn = 1'b0;
		ctl(0);
		ctl(0);
		ctl(1);
		check(64'(busy), 64'h0);
		check(64'(result.valid), 64'h0);
		ctl(0);
		i_src.pulse(0, 1);
		// the span limit is reached when the running count equals it
		res(48'h7D0, 32'h1);
		check(64'(result.overflow), 64'h1);
		$display("test interval done");
		// running total survives a fetch, arm stop ends it
		cfg = '0;
		cfg.fn = FN_EVENT_ACCUMULATE;
		ctl(0);
		tick(1);
		i_src.pulse(0, 5);
		tick(1);
		check(64'(result.primary), 64'h5);
		ctl(4);
		i_src.pulse(0, 3);
		ctl(1);
		got(48'h8);
		// external arming on input two, input one ignored
		cfg.extArmSel = 1'b1;
		cfg.accumSrc = 1'b1;
		ctl(0);
		tick(1);
		ctl(2);
		i_src.pulse(1, 4);
		i_src.pulse(0, 2);
		ctl(3);
		i_src.pulse(1, 2);
		tick(1);
		check(64'(result.primary), 64'h4);
		ctl(1);
		tick(2);
		cfg = '0;
		cfg.fn = FN_GATED_ACCUMULATE;
		ctl(0);
		tick(1);
		i_src.pulse(1, 1);
		i_src.pulse(0, 3);
		i_src.pulse(1, 1);
		got(48'h3);
		// swapped roles: input two counted, input one gates
		cfg.gateSwap = 1'b1;
		ctl(0);
		tick(1);
		i_src.pulse(0, 1);
		i_src.pulse(1, 2);
		i_src.pulse(0, 1);
		got(48'h2);
		$display("test accumulate done");
		// edge durations: forced routing, levels, copied conditioning
		cfg = '0;
		cfg.fn = FN_LEADING_EDGE_DURATION;
		tick(2);
		check(64'(front.routeCommon), 64'h1);
		check(64'(front.autoLevel), 64'h1);
		check(64'(front.in2Cond), 64'(in1Cond));
		ctl(0);
		i_src.pulse(0, 1);
		tick(1);
		i_src.pulse(1, 1);
		got(48'h3);
		cfg.fn = FN_TRAILING_EDGE_DURATION;
		inv = 3'h3;
		tick(2);
		check(64'(front.in1ThrPct), 64'(`UCMC_THR_HIGH_PCT));
		check(64'(front.in2ThrPct), 64'(`UCMC_THR_LOW_PCT));
		ctl(0);
		i_src.pulse(0, 1);
		i_src.pulse(1, 1);
		got(48'h2);
		cfg.manualLevel = 1'b1;
		tick(2);
		check(64'(front.autoLevel), 64'h0);
		$display("test edge duration done");
		give_verdict();
	end
endmodule // tb

// >>> tb/ucmc_core_assertions.sv
`timescale 1ns/100ps
`include "ucmc_consts.svh"
// ****************
// port checker
// ****************
module ucmc_core_assertions (
	input wire logic             sys_clk,
	input wire logic             reset_n,
	input wire logic [2:0]       trigIn,
	input ucmc_pkg::ucmc_cfg_s   cfg,
	input ucmc_pkg::ucmc_cond_s  in1Cond,
	input wire logic             initStart,
	input wire logic             extArmStart,
	input wire logic             fetch,
	input ucmc_pkg::ucmc_front_s front,
	input ucmc_pkg::ucmc_result_s result,
	input wire logic [2:0]       trigPulse,
	input wire logic             busy,
	input wire logic             stopArmed
);
	import ucmc_pkg::*;
	logic edgeFn;
	logic tiFn;
	// function groups
	assign edgeFn = cfg.fn inside {FN_LEADING_EDGE_DURATION, FN_TRAILING_EDGE_DURATION};
	assign tiFn = cfg.fn == FN_START_STOP_INTERVAL;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// result valid handling
	property p_startClr; !busy && initStart |=> busy && !result.valid; endproperty
	a_startClr: assert property (p_startClr) else $error("start not taken");
	property p_fetchClr; !busy && fetch |=> !result.valid; endproperty
	a_fetchClr: assert property (p_fetchClr) else $error("valid kept after fetch");
	// front-end forcing for edge durations
	property p_route; edgeFn |=> front.routeCommon; endproperty
	a_route: assert property (p_route) else $error("common routing not forced");
	property p_thr; cfg.fn == FN_LEADING_EDGE_DURATION && !cfg.manualLevel
		|=> front.in1ThrPct == `UCMC_THR_LOW_PCT && front.in2ThrPct == `UCMC_THR_HIGH_PCT;
	endproperty
	a_thr: assert property (p_thr) else $error("leading thresholds wrong");
	property p_manual; edgeFn && cfg.manualLevel |=> !front.autoLevel; endproperty
	a_manual: assert property (p_manual) else $error("auto level kept");
	property p_cond; edgeFn |=> front.in2Cond == $past(in1Cond); endproperty
	a_cond: assert property (p_cond) else $error("input two not copied");
	// interval start, stop and delay
	property p_stopEnd; tiFn && !cfg.routeCommon && !cfg.avgOn && stopArmed && trigPulse[1]
		|=> result.valid && !busy;
	endproperty
	a_stopEnd: assert property (p_stopEnd) else $error("stop did not end interval");
	property p_delay; busy && tiFn && cfg.delayOn && cfg.delayCycles > 32'h2 && !stopArmed
		&& trigPulse[0] |=> !stopArmed [*2];
	endproperty
	a_delay: assert property (p_delay) else $error("stop armed inside delay");
	// event polarity, skipped for edge durations whose slopes are fixed
	property p_slope; !edgeFn && trigPulse[0] |-> trigIn[0] != cfg.slopeNeg[0]; endproperty
	a_slope: assert property (p_slope) else $error("event on wrong edge");
	// accumulator
	property p_hold; busy && cfg.fn == FN_EVENT_ACCUMULATE && trigPulse == 3'h0
		&& !initStart && !extArmStart |=> $stable(result.primary);
	endproperty
	a_hold: assert property (p_hold) else $error("total moved without event");
	property p_max; cfg.fn == FN_EVENT_ACCUMULATE |-> result.primary <= `UCMC_ACCUM_MAX;
	endproperty
	a_max: assert property (p_max) else $error("total above limit");
endmodule // ucmc_core_assertions

bind ucmc_core ucmc_core_assertions i_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.trigIn(trigIn), .cfg(cfg), .in1Cond(in1Cond), .initStart(initStart),
	.extArmStart(extArmStart), .fetch(fetch), .front(front), .result(result),
	.trigPulse(trigPulse), .busy(busy), .stopArmed(stopArmed));

// >>> tb/ucmc_source.sv
`timescale 1ns/100ps
// ****************
// signal source behind the comparators
// ****************
module ucmc_source (
	input  wire logic       sys_clk,
	input  wire logic [2:0] inv,
	output logic [2:0]      trigIn
);
	logic [2:0] raw;
	// inv sets each line's idle level, so either slope can be served
	assign trigIn = raw ^ inv;
	initial raw = 3'h0;
	// n pulses of 5 ns high and 5 ns low, the narrowest legal width
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(negedge sys_clk);
			raw[ch] = 1'b1;
			@(negedge sys_clk);
			raw[ch] = 1'b0;
		end
	endtask
endmodule // ucmc_source
